// file: rtl/swe_class_regs.svh
/*
 * Constants for the ingress classifier: field widths, codes, table sizes.
 * Assumes inclusion by bare name from design files under rtl/.
 */
`ifndef SWE_CLASS_REGS_SVH
`define SWE_CLASS_REGS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define NUM_PORTS 3
`define NUM_VLANS 16
`define NUM_DS 64
`define VID_W 12
`define PRI_W 3
`define QUEUE_W 2

// ----------------------------------------------------------------
// Special identifiers and tree state codes
// ----------------------------------------------------------------
`define VID_NULL 12'h000
`define VID_RSVD 12'hFFF
`define STP_FWD 2'h0
`define STP_BLOCK 2'h1
`define STP_LEARN 2'h2
`define STP_LISTEN 2'h3

// ----------------------------------------------------------------
// Table reset values
// ----------------------------------------------------------------
`define PORT_DEFAULT_VLAN_IDENT_RST 15'h0001
`define REGEN_RST 24'hFAC688
`define TC_RST 16'hFA50

// ----------------------------------------------------------------
// Global ingress configuration bit positions
// ----------------------------------------------------------------
`define CFG_W 6
`define CFG_DA_PRI 0
`define CFG_VLAN_PRI 1
`define CFG_DS_PRI 2
`define CFG_PREC_PRI 3
`define CFG_VLAN_EN 4
`define CFG_MEMB_CHK 5

`endif

// file: rtl/swe_class_pkg.sv
/*
 * Types shared by the classifier files.
 * Assumes the constants header is included alongside.
 */
`include "swe_class_regs.svh"
package swe_class_pkg;
    typedef enum logic [2:0] {SRC_DA, SRC_PREC, SRC_DS, SRC_VLAN, SRC_DEF} pri_src_t;
    typedef enum {ST_IDLE, ST_LOOK, ST_DONE} cls_state_t;
endpackage : swe_class_pkg

// file: rtl/ds_table_mem.sv
/*
 * Differentiated-services priority table, 64 entries of 3 bits.
 * Assumes one clock; read data comes from a register one cycle later.
 */
`timescale 1ns/1ns
`include "swe_class_regs.svh"
module ds_table_mem (
    // Clock
    input wire logic ref_clk,
    // Write side
    input wire logic wrEn,
    input wire logic [5:0] wrAddr,
    input wire logic [`PRI_W-1:0] wrData,
    // Read side
    input wire logic [5:0] rdAddr,
    output logic [`PRI_W-1:0] rdData
);
    logic [`PRI_W-1:0] mem [0:`NUM_DS-1];

    // No reset: contents are left undefined until written
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : ds_table_mem

// file: rtl/switch_priority_vlan_stp.sv
/*
 * Ingress classifier: transmit queue choice, VLAN table lookup, tree state gating.
 * Assumes packet header fields arrive with a one-cycle pktValid strobe and that
 * software programs tables through the plain write ports before enabling sources.
 */
// Contract
// - Queue priority comes from static DA, precedence, DS table, VLAN regen, or default.
// - Non-static priorities pass through the traffic class table to four queues.
// - Static DA value is used directly as queue number.
// - Default priority comes from the port default VLAN entry priority bits.
// - Precedence is TOS top three bits, for any tagging or encapsulation.
// - DS table indexed by six top bits of TOS or traffic class.
// - DS table is not reset; host must fill it before enabling.
// - VLAN tag priority goes through a per-port regeneration table.
// - Sixteen VLAN entries hold identifier, membership and untag bits.
// - Tagged VID other than 000h or FFFh searches the table.
// - Miss gives foreign VLAN, empty membership, filtered when checking enabled.
// - Empty membership filters packets whose destination missed the address table.
// - Untagged or VID 0 uses port default VID, then looks it up.
// - Membership drives ingress, egress and containment; untag on hybrid ports only.
// - Blocking or listening discard receive, block transmit, disable learning.
// - Learning state discards and blocks but keeps learning enabled.
// - Forwarding state forwards, transmits and learns.
// - Disabled uses the blocking code with identical behaviour.
// - Static plus age entry match bypasses tree state checks; learning still follows the state.
// - With VLANs enabled, tagged VID FFFh is filtered.
`timescale 1ns/1ns
`include "swe_class_regs.svh"
module switch_priority_vlan_stp
    import swe_class_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Configuration
    input wire logic [`CFG_W-1:0] global_ingress_config,
    input wire logic [2*`NUM_PORTS-1:0] port_tree_state_reg,
    input wire logic [`NUM_PORTS-1:0] hybridPort,
    // Port default VID table writes
    input wire logic pvidWrEn,
    input wire logic [1:0] pvidWrPort,
    input wire logic [`PRI_W+`VID_W-1:0] pvidWrData,
    // Regeneration table writes (one 8x3 map per port)
    input wire logic regenWrEn,
    input wire logic [1:0] regenWrPort,
    input wire logic [8*`PRI_W-1:0] regenWrData,
    // Traffic class table (8 priorities x 2 bits)
    input wire logic tcWrEn,
    input wire logic [8*`QUEUE_W-1:0] tcWrData,
    // DS table writes
    input wire logic dsWrEn,
    input wire logic [5:0] dsWrAddr,
    input wire logic [`PRI_W-1:0] dsWrData,
    // VLAN table writes
    input wire logic vlanWrEn,
    input wire logic [3:0] vlanWrIdx,
    input wire logic [`VID_W-1:0] vlanWrVid,
    input wire logic [`NUM_PORTS-1:0] vlanWrMember,
    input wire logic [`NUM_PORTS-1:0] vlanWrUntag,
    input wire logic vlanWrValid,
    // Packet header
    input wire logic pktValid,
    input wire logic [1:0] pktSrcPort,
    input wire logic [`NUM_PORTS-1:0] pktDstPorts,
    input wire logic pktTagged,
    input wire logic [`VID_W-1:0] pktVid,
    input wire logic [`PRI_W-1:0] pktTagPri,
    input wire logic pktIpv4,
    input wire logic pktIpv6,
    input wire logic [7:0] pktTos,
    input wire logic daHit,
    input wire logic daStatic,
    input wire logic daAge,
    input wire logic [`QUEUE_W-1:0] daQueue,
    // Results
    output logic resValid,
    output logic [`QUEUE_W-1:0] resQueue,
    output logic [`VID_W-1:0] resVid,
    output logic [`NUM_PORTS-1:0] resMember,
    output logic [`NUM_PORTS-1:0] resUntag,
    output logic [`NUM_PORTS-1:0] resTxPorts,
    output logic resDrop,
    output logic resLearn
);
    // ----------------------------------------------------------------
    // Tables
    // ----------------------------------------------------------------
    logic [`PRI_W+`VID_W-1:0] pvidTbl [0:`NUM_PORTS-1];
    logic [8*`PRI_W-1:0] regenTbl [0:`NUM_PORTS-1];
    logic [8*`QUEUE_W-1:0] tcTbl;
    logic [`VID_W-1:0] vlVid [0:`NUM_VLANS-1];
    logic [`NUM_PORTS-1:0] vlMember [0:`NUM_VLANS-1];
    logic [`NUM_PORTS-1:0] vlUntag [0:`NUM_VLANS-1];
    logic [`NUM_VLANS-1:0] vlValid;
    logic [`PRI_W-1:0] dsPri;

    // Table writes; defaults give identity regen and VID 1
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < `NUM_PORTS; p++) begin
                pvidTbl[p] <= `PORT_DEFAULT_VLAN_IDENT_RST;
                regenTbl[p] <= `REGEN_RST;
            end
            tcTbl <= `TC_RST;
            vlValid <= '0;
            for (int v = 0; v < `NUM_VLANS; v++) begin
                vlVid[v] <= 12'h000;
                vlMember[v] <= 3'h0;
                vlUntag[v] <= 3'h0;
            end
        end else begin
            if (pvidWrEn && pvidWrPort < 2'h3) begin
                pvidTbl[pvidWrPort] <= pvidWrData;
            end
            if (regenWrEn && regenWrPort < 2'h3) begin
                regenTbl[regenWrPort] <= regenWrData;
            end
            if (tcWrEn) begin
                tcTbl <= tcWrData;
            end
            if (vlanWrEn) begin
                vlVid[vlanWrIdx] <= vlanWrVid;
                vlMember[vlanWrIdx] <= vlanWrMember;
                vlUntag[vlanWrIdx] <= vlanWrUntag;
                vlValid[vlanWrIdx] <= vlanWrValid;
            end
        end
    end

    // ----------------------------------------------------------------
    // Stage 1: capture header, start DS lookup
    // ----------------------------------------------------------------
    logic s1Valid;
    logic [1:0] s1Src;
    logic [`NUM_PORTS-1:0] s1Dst;
    logic s1Tagged, s1Ip4, s1Ip6, s1DaHit, s1DaStatic, s1DaAge;
    logic [`VID_W-1:0] s1Vid;
    logic [`PRI_W-1:0] s1TagPri;
    logic [7:0] s1Tos;
    logic [`QUEUE_W-1:0] s1DaQueue;

    // DS index is the six top bits of TOS or traffic class
    ds_table_mem dsMem (
        .ref_clk(ref_clk),
        .wrEn(dsWrEn),
        .wrAddr(dsWrAddr),
        .wrData(dsWrData),
        .rdAddr(pktTos[7:2]),
        .rdData(dsPri)
    );

    // Header register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1Valid <= 1'b0;
            s1Src <= 2'h0;
            s1Dst <= 3'h0;
            s1Tagged <= 1'b0;
            s1Ip4 <= 1'b0;
            s1Ip6 <= 1'b0;
            s1DaHit <= 1'b0;
            s1DaStatic <= 1'b0;
            s1DaAge <= 1'b0;
            s1Vid <= 12'h000;
            s1TagPri <= 3'h0;
            s1Tos <= 8'h00;
            s1DaQueue <= 2'h0;
        end else begin
            s1Valid <= pktValid;
            if (pktValid) begin
                s1Src <= pktSrcPort;
                s1Dst <= pktDstPorts;
                s1Tagged <= pktTagged;
                s1Ip4 <= pktIpv4;
                s1Ip6 <= pktIpv6;
                s1DaHit <= daHit;
                s1DaStatic <= daStatic;
                s1DaAge <= daAge;
                s1Vid <= pktVid;
                s1TagPri <= pktTagPri;
                s1Tos <= pktTos;
                s1DaQueue <= daQueue;
            end
        end
    end

    // ----------------------------------------------------------------
    // Stage 2: classification (combinational), registered results
    // ----------------------------------------------------------------
    logic next_resValid, next_resDrop, next_resLearn;
    logic [`QUEUE_W-1:0] next_resQueue;
    logic [`VID_W-1:0] next_resVid;
    logic [`NUM_PORTS-1:0] next_resMember, next_resUntag, next_resTxPorts;

    always_comb begin
        logic [`PRI_W+`VID_W-1:0] pv;
        logic [`VID_W-1:0] vid;
        logic [`PRI_W-1:0] pri, defPri;
        logic hit, useDa, override, srcRx, srcLearn, vlanEn, vidRsvd;
        logic [`NUM_PORTS-1:0] memb, untag, dstOk, tx;
        logic [1:0] st;
        pri_src_t src;
        pv = pvidTbl[s1Src < 2'h3 ? s1Src : 2'h0];
        defPri = pv[`PRI_W+`VID_W-1:`VID_W];
        vlanEn = global_ingress_config[`CFG_VLAN_EN];
        vidRsvd = s1Tagged && (s1Vid == `VID_RSVD);
        // Untagged or priority-tagged take the port default VID
        vid = (!s1Tagged || s1Vid == `VID_NULL) ? pv[`VID_W-1:0] : s1Vid;
        hit = 1'b0;
        memb = 3'h0;
        untag = 3'h0;
        // Search the active table; a miss leaves membership empty
        for (int v = 0; v < `NUM_VLANS; v++) begin
            if (!hit && vlValid[v] && vlVid[v] == vid && !vidRsvd) begin
                hit = 1'b1;
                memb = vlMember[v];
                untag = vlUntag[v];
            end
        end
        // Source selection with fixed precedence
        useDa = s1DaHit && s1DaStatic && global_ingress_config[`CFG_DA_PRI];
        if (useDa) begin
            src = SRC_DA;
        end else if (s1Tagged && s1Vid != `VID_NULL && global_ingress_config[`CFG_VLAN_PRI]) begin
            src = SRC_VLAN;
        end else if ((s1Ip4 || s1Ip6) && global_ingress_config[`CFG_DS_PRI]) begin
            src = SRC_DS;
        end else if (s1Ip4 && global_ingress_config[`CFG_PREC_PRI]) begin
            src = SRC_PREC;
        end else begin
            src = SRC_DEF;
        end
        case (src)
            SRC_PREC: pri = s1Tos[7:5];
            SRC_DS: pri = dsPri;
            SRC_VLAN: pri = regenTbl[s1Src < 2'h3 ? s1Src : 2'h0][s1TagPri*3 +: 3];
            default: pri = defPri;
        endcase
        // Static value is the queue; others map via traffic class
        next_resQueue = useDa ? s1DaQueue : tcTbl[pri*2 +: 2];
        // Tree state of the source; disabled shares the blocking code
        st = port_tree_state_reg[(s1Src < 2'h3 ? s1Src : 2'h0)*2 +: 2];
        override = s1DaHit && s1DaStatic && s1DaAge;
        srcRx = (st == `STP_FWD) || override;
        srcLearn = (st == `STP_FWD) || (st == `STP_LEARN);
        dstOk = 3'h0;
        for (int p = 0; p < `NUM_PORTS; p++) begin
            dstOk[p] = (port_tree_state_reg[p*2 +: 2] == `STP_FWD) || override;
        end
        // With VLANs on, membership gates containment, and egress when checking is on
        tx = s1Dst & dstOk;
        if (vlanEn && global_ingress_config[`CFG_MEMB_CHK]) begin
            tx = tx & memb;
        end
        if (vlanEn && !s1DaHit) begin
            tx = tx & memb;
        end
        next_resDrop = !srcRx || (tx == 3'h0)
            || (vlanEn && vidRsvd)
            || (vlanEn && global_ingress_config[`CFG_MEMB_CHK] && !memb[s1Src < 2'h3 ? s1Src : 2'h0]);
        if (next_resDrop) begin
            tx = 3'h0;
        end
        next_resValid = s1Valid;
        next_resLearn = s1Valid && srcLearn;
        next_resVid = vid;
        next_resMember = memb;
        next_resUntag = untag & hybridPort;
        next_resTxPorts = tx;
    end

    // Result registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            resValid <= 1'b0;
            resQueue <= 2'h0;
            resVid <= 12'h000;
            resMember <= 3'h0;
            resUntag <= 3'h0;
            resTxPorts <= 3'h0;
            resDrop <= 1'b0;
            resLearn <= 1'b0;
        end else begin
            resValid <= next_resValid;
            resQueue <= next_resQueue;
            resVid <= next_resVid;
            resMember <= next_resMember;
            resUntag <= next_resUntag;
            resTxPorts <= next_resTxPorts;
            resDrop <= next_resDrop;
            resLearn <= next_resLearn;
        end
    end
endmodule : switch_priority_vlan_stp

// file: dv/ds_host_model.sv
/* Host model that fills every DS table entry once after reset.
   Assumes the classifier clock and reset; entry value is index low bits. */
`timescale 1ns/1ns
module ds_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Table writes
    output logic dsWrEn,
    output logic [5:0] dsWrAddr,
    output logic [2:0] dsWrData,
    output logic dsFilled
);
    // Entry value differs from the precedence field on purpose
    assign dsWrData = dsWrAddr[2:0];
    // Walk all 64 entries before the source may be enabled
    always @(negedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dsWrEn <= 1'h0;
            dsWrAddr <= 6'h00;
            dsFilled <= 1'h0;
        end else if (!dsWrEn && !dsFilled) begin
            dsWrEn <= 1'h1;
        end else if (dsWrEn && dsWrAddr == 6'h3F) begin
            dsWrEn <= 1'h0;
            dsFilled <= 1'h1;
        end else if (dsWrEn) begin
            dsWrAddr <= dsWrAddr + 6'h01;
        end
    end
endmodule : ds_host_model

// file: dv/swe_class_assertions.sv
/* Port checker for the ingress classifier.
   Assumes results two cycles after pktValid and the bind at the foot. */
`timescale 1ns/1ns
`include "swe_class_regs.svh"
module swe_class_checker (
    // Clock, reset, configuration
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [`CFG_W-1:0] global_ingress_config,
    input wire logic [2*`NUM_PORTS-1:0] port_tree_state_reg,
    input wire logic [`NUM_PORTS-1:0] hybridPort,
    // Packet header
    input wire logic pktValid,
    input wire logic [1:0] pktSrcPort,
    input wire logic [`NUM_PORTS-1:0] pktDstPorts,
    input wire logic pktTagged,
    input wire logic [`VID_W-1:0] pktVid,
    input wire logic daHit,
    input wire logic daStatic,
    input wire logic daAge,
    input wire logic [`QUEUE_W-1:0] daQueue,
    // Results
    input wire logic resValid,
    input wire logic [`QUEUE_W-1:0] resQueue,
    input wire logic [`NUM_PORTS-1:0] resUntag,
    input wire logic [`NUM_PORTS-1:0] resTxPorts,
    input wire logic resDrop,
    input wire logic resLearn
);
    logic ovr;
    logic learnOk;
    logic [1:0] srcSt;
    logic [2:0] fwdMask;
    // Override, source state and forwarding ports
    assign ovr = daHit & daStatic & daAge;
    assign srcSt = 2'(port_tree_state_reg >> (2 * ((pktSrcPort == 2'h3) ? 2'h0 : pktSrcPort)));
    assign learnOk = (srcSt == `STP_FWD) || (srcSt == `STP_LEARN);
    assign fwdMask = {port_tree_state_reg[5:4] == `STP_FWD, port_tree_state_reg[3:2] == `STP_FWD,
        port_tree_state_reg[1:0] == `STP_FWD};
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    AST_LATENCY: assert property (pktValid |-> ##2 resValid)
        else $error("result missing after packet");
    AST_NO_SPURIOUS: assert property (resValid |-> $past(pktValid, 2))
        else $error("result without packet");
    AST_STATIC_QUEUE: assert property (pktValid && global_ingress_config[`CFG_DA_PRI] && daHit && daStatic
        |-> ##2 resQueue == $past(daQueue, 2)) else $error("static queue not used directly");
    AST_SRC_DROP: assert property (pktValid && !ovr && srcSt != `STP_FWD |-> ##2 resDrop)
        else $error("packet from non forwarding port kept");
    AST_TX_BLOCK: assert property (pktValid && !ovr |-> ##2 (resTxPorts & ~$past(fwdMask, 2)) == 3'h0)
        else $error("transmission to blocked port");
    AST_LEARN: assert property (pktValid |-> ##2 resLearn == $past(learnOk, 2))
        else $error("learning flag wrong for source state");
    AST_RSVD_VID: assert property (pktValid && global_ingress_config[`CFG_VLAN_EN] && pktTagged
        && pktVid == `VID_RSVD |-> ##2 resDrop) else $error("reserved VID not filtered");
    AST_OVERRIDE: assert property (pktValid && ovr && !global_ingress_config[`CFG_VLAN_EN] && pktDstPorts != 3'h0
        |-> ##2 !resDrop && resTxPorts == $past(pktDstPorts, 2)) else $error("override not forwarded");
    AST_UNTAG_HYBRID: assert property (resValid |-> (resUntag & ~$past(hybridPort, 2)) == 3'h0)
        else $error("untag on non hybrid port");
    COV_STATIC: cover property (pktValid && global_ingress_config[`CFG_DA_PRI] && daHit && daStatic);
    COV_OVR: cover property (pktValid && ovr);
    COV_DROP: cover property (resValid && resDrop);
endmodule : swe_class_checker
bind switch_priority_vlan_stp swe_class_checker chk (.ref_clk, .nrst, .global_ingress_config, .port_tree_state_reg,
    .hybridPort, .pktValid, .pktSrcPort, .pktDstPorts, .pktTagged, .pktVid, .daHit, .daStatic, .daAge, .daQueue,
    .resValid, .resQueue, .resUntag, .resTxPorts, .resDrop, .resLearn);

// file: dv/tb_top.sv
/* Self-checking bench for the ingress classifier.
   Assumes the DS host model and inputs driven on the falling edge. */
`timescale 1ns/1ns
`include "swe_class_regs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    logic ref_clk = 1'h0, nrst = 1'h0, pktValid = 1'h0, pktTagged = 1'h0, pktIpv4 = 1'h0, pktIpv6 = 1'h0;
    logic daHit = 1'h0, daStatic = 1'h0, daAge = 1'h0, pvidWrEn = 1'h0, regenWrEn = 1'h0, tcWrEn = 1'h0;
    logic vlanWrEn = 1'h0, vlanWrValid = 1'h0, dsWrEn, dsFilled, resValid, resDrop, resLearn;
    logic [5:0] global_ingress_config = 6'h00, port_tree_state_reg = 6'h00, dsWrAddr;
    logic [1:0] pvidWrPort = 2'h0, regenWrPort = 2'h0, pktSrcPort = 2'h0, daQueue = 2'h0, resQueue;
    logic [2:0] hybridPort = 3'h4, vlanWrMember = 3'h0, vlanWrUntag = 3'h0, pktDstPorts = 3'h0, pktTagPri = 3'h0;
    logic [2:0] dsWrData, resMember, resUntag, resTxPorts;
    logic [14:0] pvidWrData = 15'h0000;
    logic [23:0] regenWrData = 24'h000000;
    logic [15:0] tcWrData = 16'h0000;
    logic [3:0] vlanWrIdx = 4'h0;
    logic [11:0] vlanWrVid = 12'h000, pktVid = 12'h000, resVid;
    logic [7:0] pktTos = 8'h00;
    int err_total = 0;
    int n_checks = 0;
    // Design, host model and clock
    switch_priority_vlan_stp DUT (.ref_clk, .nrst, .global_ingress_config, .port_tree_state_reg, .hybridPort,
        .pvidWrEn, .pvidWrPort, .pvidWrData, .regenWrEn, .regenWrPort, .regenWrData, .tcWrEn, .tcWrData, .dsWrEn,
        .dsWrAddr, .dsWrData, .vlanWrEn, .vlanWrIdx, .vlanWrVid, .vlanWrMember, .vlanWrUntag, .vlanWrValid, .pktValid,
        .pktSrcPort, .pktDstPorts, .pktTagged, .pktVid, .pktTagPri, .pktIpv4, .pktIpv6, .pktTos, .daHit, .daStatic,
        .daAge, .daQueue, .resValid, .resQueue, .resVid, .resMember, .resUntag, .resTxPorts, .resDrop, .resLearn);
    ds_host_model host (.ref_clk, .nrst, .dsWrEn, .dsWrAddr, .dsWrData, .dsFilled);
    always #5 ref_clk = ~ref_clk;
    // One-cycle table write strobe
    task automatic strobe(ref logic en);
        en = 1'h1;
        @(negedge ref_clk);
        en = 1'h0;
    endtask : strobe
    // Packet with flags {ipv6, ipv4, age, static, hit}; waits for its result
    task automatic send(input logic [1:0] s, input logic [2:0] d, input logic t, input logic [11:0] v,
        input logic [2:0] p, input logic [7:0] tos, input logic [4:0] f);
        {pktSrcPort, pktDstPorts, pktTagged, pktVid, pktTagPri, pktTos} = {s, d, t, v, p, tos};
        {pktIpv6, pktIpv4, daAge, daStatic, daHit} = f;
        pktValid = 1'h1;
        @(negedge ref_clk);
        pktValid = 1'h0;
        @(negedge ref_clk);
        `CHK("resValid", 1'h1, resValid)
    endtask : send
    // Queue, transmit ports, drop and VID of the standing result
    task automatic res(input logic [1:0] q, input logic [2:0] tx, input logic dr, input logic [11:0] v);
        `CHK("resQueue", q, resQueue)
        `CHK("resTxPorts", tx, resTxPorts)
        `CHK("resDrop", dr, resDrop)
        `CHK("resVid", v, resVid)
    endtask : res
    task automatic t_default;
        send(2'h1, 3'h4, 1'h0, 12'h000, 3'h0, 8'h00, 5'h00);
        res(2'h0, 3'h4, 1'h0, 12'h001);
        pvidWrPort = 2'h1;
        pvidWrData = {3'h6, 12'h005};
        strobe(pvidWrEn);
        global_ingress_config = 6'h02;
        send(2'h1, 3'h4, 1'h1, 12'h000, 3'h2, 8'h00, 5'h00);
        res(2'h3, 3'h4, 1'h0, 12'h005);
        $display("test default done");
    endtask : t_default
    task automatic t_static;
        tcWrData = 16'h5555;
        strobe(tcWrEn);
        global_ingress_config = 6'h0F;
        send(2'h1, 3'h4, 1'h1, 12'h010, 3'h7, 8'h00, 5'h03);
        daQueue = 2'h2;
        send(2'h1, 3'h4, 1'h1, 12'h010, 3'h7, 8'h00, 5'h03);
        res(2'h2, 3'h4, 1'h0, 12'h010);
        send(2'h1, 3'h4, 1'h1, 12'h010, 3'h7, 8'h00, 5'h01);
        res(2'h1, 3'h4, 1'h0, 12'h010);
        tcWrData = 16'hFA50;
        strobe(tcWrEn);
        $display("test static done");
    endtask : t_static
    task automatic t_regen;
        regenWrPort = 2'h2;
        regenWrData = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        strobe(regenWrEn);
        global_ingress_config = 6'h02;
        send(2'h2, 3'h2, 1'h1, 12'h010, 3'h1, 8'h00, 5'h00);
        res(2'h3, 3'h2, 1'h0, 12'h010);
        send(2'h1, 3'h2, 1'h1, 12'h010, 3'h1, 8'h00, 5'h00);
        res(2'h0, 3'h2, 1'h0, 12'h010);
        $display("test regen done");
    endtask : t_regen
    task automatic t_ds;
        global_ingress_config = 6'h0C;
        send(2'h0, 3'h2, 1'h0, 12'h000, 3'h0, 8'h9C, 5'h08);
        res(2'h3, 3'h2, 1'h0, 12'h001);
        send(2'h0, 3'h2, 1'h1, 12'h010, 3'h0, 8'h04, 5'h10);
        res(2'h0, 3'h2, 1'h0, 12'h010);
        global_ingress_config = 6'h08;
        send(2'h0, 3'h2, 1'h1, 12'h010, 3'h0, 8'h9C, 5'h08);
        res(2'h2, 3'h2, 1'h0, 12'h010);
        $display("test ds done");
    endtask : t_ds
    task automatic t_vlan;
        {vlanWrIdx, vlanWrVid, vlanWrMember, vlanWrUntag, vlanWrValid} = {4'hF, 12'h010, 3'h3, 3'h6, 1'h1};
        strobe(vlanWrEn);
        global_ingress_config = 6'h10;
        send(2'h0, 3'h6, 1'h1, 12'h010, 3'h0, 8'h00, 5'h00);
        res(2'h0, 3'h2, 1'h0, 12'h010);
        `CHK("resMember", 3'h3, resMember)
        `CHK("resUntag", 3'h4, resUntag)
        send(2'h0, 3'h6, 1'h1, 12'h020, 3'h0, 8'h00, 5'h00);
        res(2'h0, 3'h0, 1'h1, 12'h020);
        send(2'h0, 3'h6, 1'h1, 12'h020, 3'h0, 8'h00, 5'h01);
        res(2'h0, 3'h6, 1'h0, 12'h020);
        global_ingress_config = 6'h30;
        send(2'h0, 3'h6, 1'h1, 12'h020, 3'h0, 8'h00, 5'h01);
        `CHK("resDrop", 1'h1, resDrop)
        send(2'h0, 3'h6, 1'h1, 12'hFFF, 3'h0, 8'h00, 5'h01);
        `CHK("resDrop", 1'h1, resDrop)
        $display("test vlan done");
    endtask : t_vlan
    task automatic t_stp;
        global_ingress_config = 6'h00;
        for (int s = 0; s < 4; s++) begin
            port_tree_state_reg = {2'h0, 2'(s), 2'h0};
            send(2'h1, 3'h4, 1'h0, 12'h000, 3'h0, 8'h00, 5'h00);
            `CHK("resDrop", 1'(s != 0), resDrop)
            `CHK("resLearn", 1'(s == 0 || s == 2), resLearn)
            port_tree_state_reg = {2'(s), 2'h0, 2'h0};
            // Network port 1 towards ports 0 and 2; forwarding port 0 keeps receiving while port 2 is not forwarding
            send(2'h1, 3'h5, 1'h0, 12'h000, 3'h0, 8'h00, 5'h00);
            `CHK("resTxPorts", (s == 0) ? 3'h5 : 3'h1, resTxPorts)
        end
        port_tree_state_reg = 6'h14;
        // Static entry with age bit set, as the host programs for frames it must see
        send(2'h1, 3'h4, 1'h0, 12'h000, 3'h0, 8'h00, 5'h07);
        // Port 1 default priority 6 maps to queue 3
        res(2'h3, 3'h4, 1'h0, 12'h005);
        port_tree_state_reg = 6'h00;
        $display("test stp done");
    endtask : t_stp
    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        repeat (8) @(negedge ref_clk);
        nrst = 1'h1;
        for (int i = 0; i < 200 && !dsFilled; i++) @(negedge ref_clk);
        `CHK("dsFilled", 1'h1, dsFilled)
        t_default();
        t_static();
        t_regen();
        t_ds();
        t_vlan();
        t_stp();
        complete_run();
    end
    // Watchdog
    initial begin
        #50000;
        err_total++;
        complete_run();
    end
endmodule : tb_top
